// file: rtl/lpf_pkg.sv
// Constants shared by the pause flow-control and wake-status block.
//------------------------------------------------------------------------
// Operation
// (RULE_01) Low-pause flag sets on nonzero low pause; clears on timer end or pause.
// (RULE_02) Paused flag sets on any received pause; clears when timer ends.
// (RULE_03) Pause-sent flag sets on nonzero pause sent; clears when timer ends.
// (RULE_04) Software uses pause and resume bits only in frame flow mode.
// (RULE_05) Writing one to pause-request forces the pause request active.
// (RULE_06) Pause-request clears only by resume write; writing zero does nothing.
// (RULE_07) A descriptor-raised pause request also sets the pause-request bit.
// (RULE_08) Writing one to resume withdraws the request and clears pause-request.
// (RULE_09) Resume bit always reads as zero.
// (RULE_10) Three-bit threshold field tells the pause generator when to start.
// (RULE_11) Reserved bits read zero; threshold resets to the fast-system code.
// (RULE_12) Link-change wake flag latches on link change; write one clears.
// (RULE_13) Remote-wake flag latches on every such packet, enables ignored.
// (RULE_14) Filter-match wake flag latches on matching packet; write one clears.
// (RULE_15) Wake-event status bit is the power-management status bit itself.
// (RULE_16) Every wake-up event sets wake-event status, enable ignored.
// (RULE_17) Write one to wake-event status clears it and drops the PME line.
//------------------------------------------------------------------------
package lpf_pkg;

	// Width in bits of the APB byte address.
	localparam int unsigned ADDR_W = 10;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] FLOW_IDX     = 8'h19;
	localparam logic [7:0] WAKE_IDX     = 8'h1b;
	localparam logic [7:0] IRQ_STAT_IDX = 8'h20;
	localparam logic [7:0] IRQ_MASK_IDX = 8'h21;

	// Flow-control register fields.
	localparam int unsigned FLOW_LOWP_BIT   = 12;
	localparam int unsigned FLOW_PAUSED_BIT = 11;
	localparam int unsigned FLOW_SENT_BIT   = 10;
	localparam int unsigned FLOW_REQ_BIT    = 9;
	localparam int unsigned FLOW_RESUME_BIT = 8;
	localparam int unsigned FLOW_THR_LSB    = 0;
	localparam int unsigned FLOW_THR_W      = 3;
	localparam logic [2:0]  FLOW_THR_RST    = 3'h0;

	// Wake-status register fields.
	localparam int unsigned WAKE_W        = 8;
	localparam int unsigned WAKE_LINK_BIT = 7;
	localparam int unsigned WAKE_RMT_BIT  = 6;
	localparam int unsigned WAKE_FILT_BIT = 5;
	localparam int unsigned WAKE_PME_BIT  = 0;
	localparam logic [7:0]  WAKE_RST      = 8'h00;

	// Interrupt status and mask layout.
	localparam int unsigned IRQ_W          = 4;
	localparam int unsigned IRQ_SENT_BIT   = 0;
	localparam int unsigned IRQ_PAUSED_BIT = 1;
	localparam int unsigned IRQ_LOWP_BIT   = 2;
	localparam int unsigned IRQ_WAKE_BIT   = 3;
	localparam logic [3:0]  IRQ_RST        = 4'h0;

endpackage : lpf_pkg

// file: rtl/lpf_wake_if.sv
// Interface between the register front end and the wake-status latch.
`timescale 1ns/100ps
`default_nettype none
interface lpf_wake_if (
	input wire logic clk,
	input wire logic rst_n
);
	logic       wr_stb;    // Software write to the wake register.
	logic [7:0] wdata;     // Write data, one bits clear flags.
	logic       link_chg;  // Link status changed.
	logic       rmt_wake;  // Remote-wake pattern packet seen.
	logic       filt_hit;  // Packet matched the filters.
	logic       wake_evt;  // Any wake-up event.
	logic       pm_clr;    // Clear from the power-management side.
	logic [7:0] status;    // Current register image.
	logic       set_evt;   // Some flag is being set this cycle.

	// Register front end drives requests and events.
	modport regs (
		output wr_stb, wdata, link_chg, rmt_wake, filt_hit, wake_evt,
		output pm_clr,
		input  clk, rst_n, status, set_evt
	);

	// Latch side answers with the register image.
	modport wake (
		input  wr_stb, wdata, link_chg, rmt_wake, filt_hit, wake_evt,
		input  pm_clr, clk, rst_n,
		output status, set_evt
	);
endinterface : lpf_wake_if
`default_nettype wire

// file: rtl/lpf_wake_status.sv
// Sticky wake-up flags with write-one-to-clear access.
`timescale 1ns/100ps
`default_nettype none
module lpf_wake_status (
	lpf_wake_if.wake w
);
	//--------------------------------------------------------------
	// Flag storage
	//--------------------------------------------------------------
	logic [2:0] flag;
	logic [2:0] flag_set;
	logic       pme_stat;

	assign flag_set = {w.link_chg, w.rmt_wake, w.filt_hit};

	// One sticky flag per event; a set in the clearing cycle wins.
	for (genvar i = 0; i < 3; i++) begin : g_flag
		localparam int unsigned POS = (i == 2) ? lpf_pkg::WAKE_LINK_BIT :
			(i == 1) ? lpf_pkg::WAKE_RMT_BIT : lpf_pkg::WAKE_FILT_BIT;
		always_ff @(posedge w.clk or negedge w.rst_n) begin
			if (!w.rst_n) begin
				flag[i] <= 1'b0;
			end else if (flag_set[i]) begin
				flag[i] <= 1'b1; // [RULE_12] [RULE_13] [RULE_14]
			end else if (w.wr_stb && w.wdata[POS]) begin
				flag[i] <= 1'b0;
			end
		end
	end

	// Wake status is the power-management status bit itself.
	always_ff @(posedge w.clk or negedge w.rst_n) begin
		if (!w.rst_n) begin
			pme_stat <= 1'b0;
		end else if (w.wake_evt) begin
			pme_stat <= 1'b1; // [RULE_16]
		end else if ((w.wr_stb && w.wdata[lpf_pkg::WAKE_PME_BIT]) || w.pm_clr) begin
			pme_stat <= 1'b0; // [RULE_15] [RULE_17]
		end
	end

	// Register image with reserved bits at zero.
	always_comb begin
		w.status = lpf_pkg::WAKE_RST;
		w.status[lpf_pkg::WAKE_LINK_BIT] = flag[2];
		w.status[lpf_pkg::WAKE_RMT_BIT] = flag[1];
		w.status[lpf_pkg::WAKE_FILT_BIT] = flag[0];
		w.status[lpf_pkg::WAKE_PME_BIT] = pme_stat;
	end

	assign w.set_evt = |flag_set | w.wake_evt;

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	a_link_latch: assert property (@(posedge w.clk) disable iff (!w.rst_n) // [RULE_12]
		w.link_chg |=> w.status[lpf_pkg::WAKE_LINK_BIT] [*2] or
			(w.status[lpf_pkg::WAKE_LINK_BIT] ##1 1'b1))
		else $error("link flag not latched");
	a_rmt_latch: assert property (@(posedge w.clk) disable iff (!w.rst_n) // [RULE_13]
		w.rmt_wake |=> w.status[lpf_pkg::WAKE_RMT_BIT])
		else $error("remote wake flag not latched");
	a_filt_hold: assert property (@(posedge w.clk) disable iff (!w.rst_n) // [RULE_14]
		w.status[lpf_pkg::WAKE_FILT_BIT] && !w.wr_stb |=>
			w.status[lpf_pkg::WAKE_FILT_BIT])
		else $error("filter flag lost without clear");
	a_pme_clear: assert property (@(posedge w.clk) disable iff (!w.rst_n) // [RULE_17]
		w.wr_stb && w.wdata[lpf_pkg::WAKE_PME_BIT] && !w.wake_evt |=>
			!w.status[lpf_pkg::WAKE_PME_BIT])
		else $error("wake status not cleared");
	a_pme_set: assert property (@(posedge w.clk) disable iff (!w.rst_n) // [RULE_16]
		w.wake_evt |=> w.status[lpf_pkg::WAKE_PME_BIT])
		else $error("wake status not set");
endmodule : lpf_wake_status
`default_nettype wire

// file: rtl/lpf_flow_wake.sv
// APB register block for pause flow control and wake-up status.
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module lpf_flow_wake (
	// Clock and reset.
	input  wire logic                       clk_sys_i,
	input  wire logic                       rst_n_i,
	// APB slave.
	input  wire logic [lpf_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic                       psel_i,
	input  wire logic                       penable_i,
	input  wire logic                       pwrite_i,
	input  wire logic [31:0]                pwdata_i,
	output logic      [31:0]                prdata_o,
	output logic                            pready_o,
	output logic                            pslverr_o,
	// Pause activity from the MAC.
	input  wire logic                       pause_rx_i,
	input  wire logic                       pause_rx_low_nz_i,
	input  wire logic                       pause_tx_nz_i,
	input  wire logic                       flow_timer_zero_i,
	input  wire logic                       rfd_pause_req_i,
	// Pause control toward the MAC.
	output logic                            pause_req_o,
	output logic      [2:0]                 fifo_thresh_o,
	// Wake-up events and power management.
	input  wire logic                       link_change_i,
	input  wire logic                       remote_wake_pkt_i,
	input  wire logic                       filter_match_i,
	input  wire logic                       wake_event_i,
	input  wire logic                       pm_status_clr_i,
	input  wire logic                       pme_en_i,
	output logic                            pm_status_o,
	output logic                            pme_o,
	output logic                            pm_status_clr_o,
	// Interrupt.
	output logic                            irq_o
);
	//--------------------------------------------------------------
	// Address decode
	//--------------------------------------------------------------

	// True when a byte address equals the word-aligned address of a register index.
	function automatic logic lpf_hit(
		input logic [lpf_pkg::ADDR_W-1:0] addr,
		input logic [7:0]                 idx
	);
		lpf_hit = (addr == {idx, 2'b00});
	endfunction : lpf_hit

	logic hit_flow;
	logic hit_wake;
	logic hit_ist;
	logic hit_imask;
	logic mapped;
	logic acc_wr;
	logic setup_rd;

	assign hit_flow  = lpf_hit(paddr_i, lpf_pkg::FLOW_IDX);
	assign hit_wake  = lpf_hit(paddr_i, lpf_pkg::WAKE_IDX);
	assign hit_ist   = lpf_hit(paddr_i, lpf_pkg::IRQ_STAT_IDX);
	assign hit_imask = lpf_hit(paddr_i, lpf_pkg::IRQ_MASK_IDX);
	assign mapped    = hit_flow | hit_wake | hit_ist | hit_imask;

	// Writes act at the access edge, reads are captured in setup.
	assign acc_wr   = psel_i & penable_i & pwrite_i & mapped;
	assign setup_rd = psel_i & ~penable_i & ~pwrite_i;

	// Zero-wait slave; unmapped words answer with an error.
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;

	//--------------------------------------------------------------
	// Flow-control register
	//--------------------------------------------------------------
	logic       flow_wr;
	logic       lowp;
	logic       paused;
	logic       sent;
	logic       preq;
	logic [2:0] thresh;
	logic       lowp_set;
	logic       preq_set;
	logic       preq_clr;

	assign flow_wr  = acc_wr & hit_flow;
	assign lowp_set = pause_rx_i & pause_rx_low_nz_i;
	assign preq_set = (flow_wr & pwdata_i[lpf_pkg::FLOW_REQ_BIT]) |
		rfd_pause_req_i;
	assign preq_clr = flow_wr & pwdata_i[lpf_pkg::FLOW_RESUME_BIT];

	// Low-priority pause received.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lowp <= 1'b0;
		end else if (lowp_set) begin
			lowp <= 1'b1; // [RULE_01]
		end else if (flow_timer_zero_i || pause_rx_i) begin
			lowp <= 1'b0; // [RULE_01]
		end
	end

	// Paused by any received pause.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			paused <= 1'b0;
		end else if (pause_rx_i) begin
			paused <= 1'b1; // [RULE_02]
		end else if (flow_timer_zero_i) begin
			paused <= 1'b0; // [RULE_02]
		end
	end

	// Pause frame with a nonzero value sent.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sent <= 1'b0;
		end else if (pause_tx_nz_i) begin
			sent <= 1'b1; // [RULE_03]
		end else if (flow_timer_zero_i) begin
			sent <= 1'b0; // [RULE_03]
		end
	end

	// Pause request: set by software or a descriptor, cleared by resume.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			preq <= 1'b0;
		end else if (preq_set) begin
			preq <= 1'b1; // [RULE_05] [RULE_07]
		end else if (preq_clr) begin
			preq <= 1'b0; // [RULE_06] [RULE_08]
		end
	end

	// Threshold code for the pause generator.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			thresh <= lpf_pkg::FLOW_THR_RST; // [RULE_11]
		end else if (flow_wr) begin
			thresh <= pwdata_i[lpf_pkg::FLOW_THR_LSB +: lpf_pkg::FLOW_THR_W];
		end
	end

	// The request acts as a full receive FIFO extender in the MAC.
	assign pause_req_o   = preq;   // [RULE_05]
	assign fifo_thresh_o = thresh; // [RULE_10]

	//--------------------------------------------------------------
	// Wake-status register
	//--------------------------------------------------------------
	lpf_wake_if u_wif (
		.clk   (clk_sys_i),
		.rst_n (rst_n_i)
	);

	assign u_wif.wr_stb   = acc_wr & hit_wake;
	assign u_wif.wdata    = pwdata_i[lpf_pkg::WAKE_W-1:0];
	assign u_wif.link_chg = link_change_i;
	assign u_wif.rmt_wake = remote_wake_pkt_i;
	assign u_wif.filt_hit = filter_match_i;
	assign u_wif.wake_evt = wake_event_i;
	assign u_wif.pm_clr   = pm_status_clr_i;

	lpf_wake_status u_wake (
		.w (u_wif.wake)
	);

	// Mirror toward the power-management register and the PME line.
	assign pm_status_o = u_wif.status[lpf_pkg::WAKE_PME_BIT];     // [RULE_15]
	assign pme_o       = pm_status_o & pme_en_i;                 // [RULE_17]
	assign pm_status_clr_o = u_wif.wr_stb &
		u_wif.wdata[lpf_pkg::WAKE_PME_BIT] & ~wake_event_i;  // [RULE_17]

	//--------------------------------------------------------------
	// Interrupt status and mask
	//--------------------------------------------------------------
	logic [3:0] irq_stat;
	logic [3:0] irq_mask;
	logic [3:0] irq_ev;

	// Events that raise sticky interrupt bits.
	always_comb begin
		irq_ev = lpf_pkg::IRQ_RST;
		irq_ev[lpf_pkg::IRQ_SENT_BIT]   = pause_tx_nz_i;
		irq_ev[lpf_pkg::IRQ_PAUSED_BIT] = pause_rx_i;
		irq_ev[lpf_pkg::IRQ_LOWP_BIT]   = lowp_set;
		irq_ev[lpf_pkg::IRQ_WAKE_BIT]   = u_wif.set_evt;
	end

	// Sticky bits; an event in the clearing cycle survives the clear.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_stat <= lpf_pkg::IRQ_RST;
		end else if (acc_wr && hit_ist) begin
			irq_stat <= (irq_stat & ~pwdata_i[3:0]) | irq_ev;
		end else begin
			irq_stat <= irq_stat | irq_ev;
		end
	end

	// Mask register, same layout as the status.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_mask <= lpf_pkg::IRQ_RST;
		end else if (acc_wr && hit_imask) begin
			irq_mask <= pwdata_i[3:0];
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	//--------------------------------------------------------------
	// Read data
	//--------------------------------------------------------------
	logic [31:0] rd_val;

	// Register images; reserved and resume bits read as zero.
	always_comb begin
		rd_val = 32'h0000_0000;
		if (hit_flow) begin
			rd_val[lpf_pkg::FLOW_LOWP_BIT]   = lowp;
			rd_val[lpf_pkg::FLOW_PAUSED_BIT] = paused;
			rd_val[lpf_pkg::FLOW_SENT_BIT]   = sent;
			rd_val[lpf_pkg::FLOW_REQ_BIT]    = preq;
			rd_val[lpf_pkg::FLOW_THR_LSB +: lpf_pkg::FLOW_THR_W] = thresh;
		end else if (hit_wake) begin
			rd_val[lpf_pkg::WAKE_W-1:0] = u_wif.status;
		end else if (hit_ist) begin
			rd_val[lpf_pkg::IRQ_W-1:0] = irq_stat;
		end else if (hit_imask) begin
			rd_val[lpf_pkg::IRQ_W-1:0] = irq_mask;
		end
	end // [RULE_09] [RULE_11]

	// Read data is captured in the setup cycle and held.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup_rd) begin
			prdata_o <= rd_val;
		end
	end

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	sequence s_flow_wr;
		psel_i && penable_i && pwrite_i && hit_flow;
	endsequence

	sequence s_flow_rd;
		psel_i && !penable_i && !pwrite_i && hit_flow ##1 penable_i;
	endsequence

	a_resume_clears: assert property (@(posedge clk_sys_i) // [RULE_08]
		disable iff (!rst_n_i)
		s_flow_wr ##0 pwdata_i[lpf_pkg::FLOW_RESUME_BIT] &&
			!pwdata_i[lpf_pkg::FLOW_REQ_BIT] && !rfd_pause_req_i
		|=> !pause_req_o)
		else $error("resume did not drop pause request");
	a_req_holds: assert property (@(posedge clk_sys_i) // [RULE_06]
		disable iff (!rst_n_i)
		pause_req_o && !preq_clr |=> pause_req_o)
		else $error("pause request lost without resume");
	a_rfd_sets_req: assert property (@(posedge clk_sys_i) // [RULE_07]
		disable iff (!rst_n_i)
		rfd_pause_req_i |=> pause_req_o)
		else $error("descriptor pause request not taken");
	a_resume_reads: assert property (@(posedge clk_sys_i) // [RULE_09]
		disable iff (!rst_n_i)
		s_flow_rd |-> !prdata_o[lpf_pkg::FLOW_RESUME_BIT] &&
			prdata_o[15:13] == 3'h0 && prdata_o[7:3] == 5'h00)
		else $error("resume or reserved bit read nonzero");
	a_sent_cycle: assert property (@(posedge clk_sys_i) // [RULE_03]
		disable iff (!rst_n_i)
		pause_tx_nz_i ##1 (flow_timer_zero_i && !pause_tx_nz_i)
		|=> !sent ##0 $past(sent))
		else $error("pause sent flag cycle wrong");
	a_paused_set: assert property (@(posedge clk_sys_i) // [RULE_02]
		disable iff (!rst_n_i)
		pause_rx_i |=> paused)
		else $error("paused flag not set");
	a_paused_clr: assert property (@(posedge clk_sys_i) // [RULE_02]
		disable iff (!rst_n_i)
		flow_timer_zero_i && !pause_rx_i |=> !paused)
		else $error("paused flag not cleared");
	a_lowp_clr: assert property (@(posedge clk_sys_i) // [RULE_01]
		disable iff (!rst_n_i)
		(pause_rx_i && !pause_rx_low_nz_i) || (flow_timer_zero_i && !lowp_set)
		|=> !lowp)
		else $error("low pause flag not cleared");
	a_lowp_set: assert property (@(posedge clk_sys_i) // [RULE_01]
		disable iff (!rst_n_i)
		lowp_set |=> lowp)
		else $error("low pause flag not set");
	a_thresh_upd: assert property (@(posedge clk_sys_i) // [RULE_10]
		disable iff (!rst_n_i)
		s_flow_wr |=> fifo_thresh_o == $past(pwdata_i[2:0]))
		else $error("threshold not written");
	a_pme_drop: assert property (@(posedge clk_sys_i) // [RULE_17]
		disable iff (!rst_n_i)
		pm_status_clr_o |=> !pme_o && !pm_status_o)
		else $error("PME line not dropped on clear");
	a_irq_level: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		$rose(irq_stat[lpf_pkg::IRQ_SENT_BIT]) &&
			irq_mask[lpf_pkg::IRQ_SENT_BIT] |-> irq_o)
		else $error("interrupt not raised");

	// Request, sent flag, threshold, read data, refusal and PME line checks.
	a_req_sw_set: assert property (@(posedge clk_sys_i) // [RULE_05]
		disable iff (!rst_n_i)
		s_flow_wr ##0 pwdata_i[lpf_pkg::FLOW_REQ_BIT] |=> pause_req_o)
		else $error("software pause request not taken");
	a_zero_keeps: assert property (@(posedge clk_sys_i) // [RULE_06]
		disable iff (!rst_n_i)
		s_flow_wr ##0 !pwdata_i[lpf_pkg::FLOW_RESUME_BIT] && pause_req_o
		|=> pause_req_o)
		else $error("pause request cleared without resume");
	a_sent_set: assert property (@(posedge clk_sys_i) // [RULE_03]
		disable iff (!rst_n_i)
		pause_tx_nz_i |=> sent)
		else $error("pause sent flag not set");
	a_thresh_hold: assert property (@(posedge clk_sys_i) // [RULE_10]
		disable iff (!rst_n_i)
		!flow_wr |=> $stable(fifo_thresh_o))
		else $error("threshold changed without write");
	a_rd_stands: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		!setup_rd |=> $stable(prdata_o))
		else $error("read data changed outside setup");
	a_unmapped_err: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		psel_i && penable_i && !mapped |-> pslverr_o && pready_o)
		else $error("unmapped access not refused");
	a_pme_gate: assert property (@(posedge clk_sys_i) // [RULE_15]
		disable iff (!rst_n_i)
		pm_status_o && pme_en_i |-> pme_o)
		else $error("PME line not raised");
endmodule : lpf_flow_wake
`default_nettype wire

// file: test/lpf_mac_model.sv
// Behavioural MAC and wake-logic partner that issues event pulses.
`timescale 1ns/100ps
`default_nettype none
module lpf_mac_model (
	// Clock.
	input  wire logic       clk_sys_i,
	// Events asked for by the bench, same bit order as the pulses.
	input  wire logic [9:0] req_i,
	// Event pulses: 0 pause rx, 1 low nonzero, 2 tx nonzero, 3 timer zero,
	// 4 descriptor request, 5 link, 6 remote wake, 7 filter, 8 wake, 9 pm clear.
	output logic      [9:0] ev_o
);
	logic [9:0] req_q;

	// Earlier request, so a held request gives only one pulse.
	always_ff @(posedge clk_sys_i) begin
		req_q <= req_i;
	end

	// Each new request shows one cycle later for exactly one cycle.
	always_ff @(posedge clk_sys_i) begin
		ev_o <= req_i & ~req_q;
	end
endmodule : lpf_mac_model
`default_nettype wire

// file: test/test_lan_pause_flow_and_wake_status.sv
// Self-checking bench for the pause flow-control and wake-status block.
`timescale 1ns/100ps
`default_nettype none
module test_lan_pause_flow_and_wake_status;
	localparam logic [9:0] A_FLOW = {lpf_pkg::FLOW_IDX, 2'b00};
	localparam logic [9:0] A_WAKE = {lpf_pkg::WAKE_IDX, 2'b00};
	localparam logic [9:0] A_STAT = {lpf_pkg::IRQ_STAT_IDX, 2'b00};
	localparam logic [9:0] A_MASK = {lpf_pkg::IRQ_MASK_IDX, 2'b00};
	localparam logic [9:0] A_BAD  = 10'h3fc;
	localparam logic [31:0] M_LOW = 32'h1 << lpf_pkg::FLOW_LOWP_BIT;
	localparam logic [31:0] M_PAU = 32'h1 << lpf_pkg::FLOW_PAUSED_BIT;
	localparam logic [31:0] M_TX  = 32'h1 << lpf_pkg::FLOW_SENT_BIT;
	localparam logic [31:0] M_REQ = 32'h1 << lpf_pkg::FLOW_REQ_BIT;
	localparam logic [31:0] M_RES = 32'h1 << lpf_pkg::FLOW_RESUME_BIT;
	localparam logic [31:0] M_PME = 32'h1 << lpf_pkg::WAKE_PME_BIT;
	localparam logic [31:0] M_WK  = (32'h1 << lpf_pkg::WAKE_LINK_BIT) |
		(32'h1 << lpf_pkg::WAKE_RMT_BIT) | (32'h1 << lpf_pkg::WAKE_FILT_BIT);

	logic        clk_sys_i, rst_n_i, psel, penable, pwrite, pme_en;
	logic [9:0]  paddr, ev, ev_req;
	logic [31:0] pwdata, prdata_o, q;
	logic        pready_o, pslverr_o, pause_req_o, pm_status_o, pme_o, irq_o;
	logic        e, pm_clr_o;
	logic [2:0]  fifo_thresh_o;
	int          err_total, n_tests, cyc, n_clr;

	lpf_mac_model u_mac (.clk_sys_i(clk_sys_i), .req_i(ev_req), .ev_o(ev));

	lpf_flow_wake u_dut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .pause_rx_i(ev[0]),
		.pause_rx_low_nz_i(ev[1]), .pause_tx_nz_i(ev[2]),
		.flow_timer_zero_i(ev[3]), .rfd_pause_req_i(ev[4]),
		.pause_req_o(pause_req_o), .fifo_thresh_o(fifo_thresh_o),
		.link_change_i(ev[5]), .remote_wake_pkt_i(ev[6]),
		.filter_match_i(ev[7]), .wake_event_i(ev[8]),
		.pm_status_clr_i(ev[9]), .pme_en_i(pme_en),
		.pm_status_o(pm_status_o), .pme_o(pme_o), .pm_status_clr_o(pm_clr_o),
		.irq_o(irq_o));

	// 40 MHz clock.
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	//------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	// Compares a seen value with the expected one.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; holds the request until pready is seen high.
	task automatic apb(input logic w, input logic [9:0] a,
		input logic [31:0] d);
		@(posedge clk_sys_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		do @(posedge clk_sys_i); while (pready_o !== 1'b1);
		q = prdata_o;
		e = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk_sys_i);
	endtask : apb

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [9:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rd

	// Asks the partner for one pulse of the chosen events, waits it out.
	task automatic send(input logic [9:0] v);
		@(posedge clk_sys_i);
		ev_req <= v;
		@(posedge clk_sys_i);
		ev_req <= 10'h000;
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask : send

	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic t_reset;
		rd(A_FLOW, 32'h0);
		rd(A_WAKE, 32'h0);
		rd(A_STAT, 32'h0);
		rd(A_MASK, 32'h0);
		chk({27'h0, pause_req_o, pm_status_o, pme_o, irq_o, 1'b0}, 32'h0);
		chk({29'h0, fifo_thresh_o}, {29'h0, lpf_pkg::FLOW_THR_RST});
	endtask : t_reset

	// Every threshold code, then most reserved bits and the low-pause bit written high.
	task automatic t_thresh;
		for (int i = 0; i < 8; i++) begin
			wr(A_FLOW, 32'(i));
			chk({29'h0, fifo_thresh_o}, 32'(i));
		end
		wr(A_FLOW, 32'hffff_f0f7);
		rd(A_FLOW, 32'h7);
		wr(A_FLOW, 32'h2);
	endtask : t_thresh

	// Pause bits are used as in frame-based flow control mode.
	task automatic t_req;
		wr(A_FLOW, M_REQ | 32'h2);
		chk({31'h0, pause_req_o}, 32'h1);
		rd(A_FLOW, M_REQ | 32'h2);
		wr(A_FLOW, 32'h2);
		chk({31'h0, pause_req_o}, 32'h1);
		wr(A_FLOW, M_RES | 32'h2);
		chk({31'h0, pause_req_o}, 32'h0);
		rd(A_FLOW, 32'h2);
		send(10'h010);
		rd(A_FLOW, M_REQ | 32'h2);
		wr(A_FLOW, M_REQ | M_RES | 32'h2);
		chk({31'h0, pause_req_o}, 32'h1);
		wr(A_FLOW, M_RES | 32'h2);
		rd(A_FLOW, 32'h2);
	endtask : t_req

	task automatic t_pause;
		send(10'h004);
		rd(A_FLOW, M_TX | 32'h2);
		send(10'h008);
		rd(A_FLOW, 32'h2);
		// Pause sent, then the timer ends in the very next cycle.
		@(posedge clk_sys_i);
		ev_req <= 10'h004;
		@(posedge clk_sys_i);
		ev_req <= 10'h008;
		send(10'h000);
		rd(A_FLOW, 32'h2);
		send(10'h003);
		rd(A_FLOW, M_LOW | M_PAU | 32'h2);
		send(10'h001);
		rd(A_FLOW, M_PAU | 32'h2);
		send(10'h003);
		send(10'h008);
		rd(A_FLOW, 32'h2);
	endtask : t_pause

	task automatic t_wake;
		int c0;
		c0 = n_clr;
		send(10'h1e0);
		rd(A_WAKE, M_WK | M_PME);
		chk({30'h0, pm_status_o, pme_o}, 32'h2);
		@(posedge clk_sys_i);
		pme_en <= 1'b1;
		@(negedge clk_sys_i);
		chk({31'h0, pme_o}, 32'h1);
		wr(A_WAKE, M_PME);
		chk(32'(n_clr - c0), 32'h1);
		rd(A_WAKE, M_WK);
		chk({30'h0, pm_status_o, pme_o}, 32'h0);
		wr(A_WAKE, M_WK);
		rd(A_WAKE, 32'h0);
		chk(32'(n_clr - c0), 32'h1);
		send(10'h100);
		chk({31'h0, pm_status_o}, 32'h1);
		send(10'h200);
		chk({30'h0, pm_status_o, pme_o}, 32'h0);
	endtask : t_wake

	// Interrupt masking and clearing, then an unmapped address.
	task automatic t_irq;
		rd(A_STAT, 32'hf);
		chk({31'h0, irq_o}, 32'h0);
		wr(A_MASK, 32'h4);
		chk({31'h0, irq_o}, 32'h1);
		wr(A_STAT, 32'h4);
		chk({31'h0, irq_o}, 32'h0);
		rd(A_STAT, 32'hb);
		wr(A_MASK, 32'hf);
		chk({31'h0, irq_o}, 32'h1);
		wr(A_STAT, 32'hf);
		chk({31'h0, irq_o}, 32'h0);
		wr(A_BAD, 32'hffff_ffff);
		chk({31'h0, e}, 32'h1);
		rd(A_BAD, 32'h0);
		chk({31'h0, e}, 32'h1);
		rd(A_FLOW, 32'h2);
	endtask : t_irq

	// Counts software clear pulses and cuts a hang short.
	always @(posedge clk_sys_i) begin
		if (pm_clr_o === 1'b1)
			n_clr++;
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			test_done();
		end
	end

	initial begin
		{psel, penable, pwrite, pme_en, rst_n_i} = 5'h0;
		paddr = 10'h000;
		ev_req = 10'h000;
		pwdata = 32'h0;
		{err_total, n_tests, cyc, n_clr} = 0;
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_thresh();
		t_req();
		t_pause();
		t_wake();
		t_irq();
		test_done();
	end
endmodule : test_lan_pause_flow_and_wake_status
`default_nettype wire
